// [rtl/adc_readout_pkg.sv]
// Shared constants for the serial converter readout block
package adc_readout_pkg;
  localparam int RESULT_BITS = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] ENABLE_FALL = 4'h2;
  localparam logic [3:0] SAMPLE_FALLS = 4'h2;
  localparam logic [3:0] CONV_CYCLES = 4'hc;
  localparam logic [3:0] BIT_INDEX_MSB = 4'hb;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam int LINK_PERIOD_NS = 80;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
endpackage : adc_readout_pkg

// [rtl/sample_fifo.sv]
// Small synchronous FIFO holding converted samples
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  logic rdy_reg, rdy_next;

  // Ready is registered from the next count so the top-level output comes from a flip-flop
  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    rdy_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  // Storage needs no reset; only pointers define contents
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule : sample_fifo

// [rtl/adc_serial_readout.sv]
// Serial readout and conversion sequencer of a 12-bit sampling converter
`timescale 1ns/1ns
// What this block does
// - Select low means chip selected; select high means shutdown.
// - Each result sent on the serial output is 12 data bits.
// - Output driver turns on at the second clock pulse after select falls.
// - After enable, one null bit, then result bits on the next 12 edges.
// - Host data clock paces both the serial transfer and the conversion.
// - Serial output changes to the next bit on each falling clock edge.
// - Select falling starts a new sample, conversion and transfer sequence.
// - Select rising resets the sequencer, ready for the next exchange.
// - Input is sampled for 1.5 to 2 clock cycles at sequence start.
// - With clock still running, result repeats LSB first from bit 1, then zeroes.
// - Conversion circuitry powers down at conversion end, even select low.
module adc_serial_readout #(
  parameter int WIDTH = adc_readout_pkg::RESULT_BITS,
  parameter int DEPTH = adc_readout_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic select_shutdown_n,
  input wire logic transfer_conversion_clock,
  input wire logic [WIDTH-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic dout_o,
  output logic dout_oe,
  output logic sampling,
  output logic converting,
  output logic powered,
  output logic [WIDTH-1:0] result_data,
  output logic result_valid,
  input wire logic result_ready
);
  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_SAMPLE, ST_NULL, ST_MSB_FIRST, ST_LSB_FIRST, ST_ZEROES
  } seq_t;

  // Pin synchronisers: first stage feeds only the second
  logic [1:0] sel_sync_reg, sel_sync_next;
  logic [1:0] clk_sync_reg, clk_sync_next;
  logic sel_d_reg, sel_d_next, clk_d_reg, clk_d_next;
  logic sel_n, lclk, sel_fall, sel_rise, lclk_fall;

  // Sequencer state
  seq_t state_reg, state_next;
  logic [3:0] fall_cnt_reg, fall_cnt_next;
  logic [3:0] bit_idx_reg, bit_idx_next;
  logic [WIDTH-1:0] shift_reg, shift_next;
  logic dout_reg, dout_next, oe_reg, oe_next;
  logic smp_reg, smp_next, conv_reg, conv_next, pwr_reg, pwr_next;
  logic [WIDTH-1:0] res_reg, res_next;
  logic res_v_reg, res_v_next;

  // FIFO drain side
  logic [WIDTH-1:0] fifo_data;
  logic fifo_valid, fifo_take;

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  assign sel_n = sel_sync_reg[1];
  assign lclk = clk_sync_reg[1];
  assign sel_fall = sel_d_reg && !sel_n;
  assign sel_rise = !sel_d_reg && sel_n;
  assign lclk_fall = clk_d_reg && !lclk;
  // Pull a sample only at the end of a sampling window, on the second clock fall, so a stall holds the FIFO back
  assign fifo_take = (state_reg == ST_SAMPLE) && lclk_fall && !sel_n
    && (fall_cnt_reg == adc_readout_pkg::SAMPLE_FALLS - 4'h1);

  always_comb begin
    sel_sync_next = {sel_sync_reg[0], select_shutdown_n};
    clk_sync_next = {clk_sync_reg[0], transfer_conversion_clock};
    sel_d_next = sel_n;
    clk_d_next = lclk;
  end

  always_comb begin
    state_next = state_reg;
    fall_cnt_next = fall_cnt_reg;
    bit_idx_next = bit_idx_reg;
    shift_next = shift_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    smp_next = smp_reg;
    conv_next = conv_reg;
    pwr_next = pwr_reg;
    res_next = res_reg;
    res_v_next = res_v_reg && !result_ready;
    if (sel_n) begin
      // Shutdown while select is high, output released
      state_next = ST_SHUTDOWN;
      oe_next = 1'b0;
      dout_next = 1'b0;
      smp_next = 1'b0;
      conv_next = 1'b0;
      pwr_next = 1'b0;
      fall_cnt_next = '0;
      bit_idx_next = '0;
    end else if (sel_fall) begin
      state_next = ST_SAMPLE;
      fall_cnt_next = '0;
      smp_next = 1'b1;
      pwr_next = 1'b1;
    end else if (lclk_fall) begin
      // Apart from select fall and select high, sequencing advances on link clock falling edges only
      unique case (state_reg)
        ST_SHUTDOWN: begin
          state_next = ST_SHUTDOWN;
        end
        ST_SAMPLE: begin
          fall_cnt_next = fall_cnt_reg + 4'h1;
          if (fall_cnt_reg + 4'h1 == adc_readout_pkg::ENABLE_FALL) begin
            // Window from select fall to second falling edge: 1.5 to 2 clocks
            smp_next = 1'b0;
            conv_next = 1'b1;
            oe_next = 1'b1;
            dout_next = 1'b0;
            shift_next = fifo_valid ? fifo_data : adc_readout_pkg::RESULT_RESET;
            state_next = ST_NULL;
          end
        end
        ST_NULL: begin
          dout_next = shift_reg[WIDTH-1];
          bit_idx_next = adc_readout_pkg::BIT_INDEX_MSB;
          state_next = ST_MSB_FIRST;
        end
        ST_MSB_FIRST: begin
          if (bit_idx_reg == 4'h0) begin
            // Conversion ends one fall after the last result bit, as the LSB first tail starts
            conv_next = 1'b0;
            pwr_next = 1'b0;
            res_next = shift_reg;
            res_v_next = 1'b1;
            dout_next = shift_reg[1];
            bit_idx_next = 4'h1;
            state_next = ST_LSB_FIRST;
          end else begin
            bit_idx_next = bit_idx_reg - 4'h1;
            dout_next = shift_reg[bit_idx_reg - 4'h1];
          end
        end
        ST_LSB_FIRST: begin
          if (bit_idx_reg == adc_readout_pkg::BIT_INDEX_MSB) begin
            dout_next = 1'b0;
            state_next = ST_ZEROES;
          end else begin
            bit_idx_next = bit_idx_reg + 4'h1;
            dout_next = shift_reg[bit_idx_reg + 4'h1];
          end
        end
        ST_ZEROES: begin
          dout_next = 1'b0;
        end
        default: begin
          state_next = ST_SHUTDOWN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      sel_d_reg <= 1'b1;
      clk_d_reg <= 1'b0;
    end else if (ce) begin
      sel_sync_reg <= sel_sync_next;
      clk_sync_reg <= clk_sync_next;
      sel_d_reg <= sel_d_next;
      clk_d_reg <= clk_d_next;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_SHUTDOWN;
      fall_cnt_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      shift_reg <= adc_readout_pkg::RESULT_RESET;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      smp_reg <= 1'b0;
      conv_reg <= 1'b0;
      pwr_reg <= 1'b0;
      res_reg <= adc_readout_pkg::RESULT_RESET;
      res_v_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      fall_cnt_reg <= fall_cnt_next;
      bit_idx_reg <= bit_idx_next;
      shift_reg <= shift_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      smp_reg <= smp_next;
      conv_reg <= conv_next;
      pwr_reg <= pwr_next;
      res_reg <= res_next;
      res_v_reg <= res_v_next;
    end
  end

  assign dout_o = dout_reg;
  assign dout_oe = oe_reg;
  assign sampling = smp_reg;
  assign converting = conv_reg;
  assign powered = pwr_reg;
  assign result_data = res_reg;
  assign result_valid = res_v_reg;
endmodule : adc_serial_readout

// [testbench/adc_readout_monitor.sv]
// Checker on the ports of the serial readout block
`timescale 1ns/1ns
module adc_readout_monitor #(
  parameter int WIDTH = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic select_shutdown_n,
  input wire logic transfer_conversion_clock,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic sampling,
  input wire logic converting,
  input wire logic powered,
  input wire logic [WIDTH-1:0] result_data,
  input wire logic result_valid,
  input wire logic result_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Five cycles cover the pin synchroniser plus the output register
  chk_shutdown_hiz: assert property (select_shutdown_n [*5] |-> !dout_oe && !powered)
    else $error("driven or powered in shutdown");
  chk_shutdown_idle: assert property (select_shutdown_n [*5] |-> !sampling && !converting)
    else $error("sequencer busy in shutdown");
  chk_enable_cause: assert property ($rose(dout_oe) |-> !select_shutdown_n && !transfer_conversion_clock)
    else $error("enable without select and clock fall");
  chk_shift_on_fall: assert property ($changed(dout_o) |-> !transfer_conversion_clock || select_shutdown_n)
    else $error("output changed while clock high");
  chk_sample_window: assert property (sampling |-> !dout_oe && !converting)
    else $error("sampling overlaps transfer");
  chk_convert_powered: assert property (converting |-> dout_oe && powered)
    else $error("converting while off");
  chk_enable_holds: assert property (dout_oe && !select_shutdown_n |=> dout_oe)
    else $error("enable dropped while selected");
  chk_result_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result lost before accepted");
  cover property ($rose(result_valid));
  cover property ($fell(dout_oe));
  chk_power_down_end: assert property ($rose(result_valid) |-> !powered && !converting && dout_oe)
    else $error("still powered after conversion end");
  cover property ($fell(converting));
  cover property ($fell(sampling) && dout_oe);
endmodule : adc_readout_monitor

// [testbench/host_model.sv]
// Host side: drives select and data clock, samples the serial line on clock rise
`timescale 1ns/1ns
module host_model (
  input wire logic mclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  output logic select_shutdown_n,
  output logic transfer_conversion_clock
);
  initial begin
    select_shutdown_n = 1'b1;
    transfer_conversion_clock = 1'b1;
  end
  task automatic half();
    repeat (adc_readout_pkg::LINK_HALF_CYCLES) @(posedge mclk);
  endtask : half
  // Clock stands high between frames; a released line reads as the inverse of the last bit
  task automatic exchange(input int falls, output logic [31:0] bits, output logic [31:0] oe);
    bits = 32'h0;
    oe = 32'h0;
    select_shutdown_n <= 1'b0;
    half();
    for (int i = 1; i <= falls; i++) begin
      transfer_conversion_clock <= 1'b0;
      half();
      transfer_conversion_clock <= 1'b1;
      bits[i] = dout_oe ? dout_o : ~bits[i-1];
      oe[i] = dout_oe;
      half();
    end
    select_shutdown_n <= 1'b1;
    half();
  endtask : exchange
endmodule : host_model

// [testbench/tb_top.sv]
// Top bench for the serial readout block
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sample_valid = 1'b0;
  logic result_ready = 1'b0;
  logic [11:0] sample_data = 12'h000;
  logic sel_n, dclk, sample_ready, dout_o, dout_oe, result_valid;
  logic [11:0] result_data;
  int fails = 0;
  int check_count = 0;
  initial forever #4 mclk = ~mclk;
  adc_serial_readout DUT (.mclk(mclk), .nrst(nrst), .ce(1'b1), .select_shutdown_n(sel_n),
    .transfer_conversion_clock(dclk), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .dout_o(dout_o), .dout_oe(dout_oe), .sampling(),
    .converting(), .powered(), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));
  host_model host (.mclk(mclk), .dout_o(dout_o), .dout_oe(dout_oe),
    .select_shutdown_n(sel_n), .transfer_conversion_clock(dclk));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Null bit, MSB first word, LSB first tail from bit 1, then zeroes
  function automatic logic [31:0] expect_bits(input logic [11:0] d, input int n);
    logic [31:0] e;
    e = 32'h2;
    for (int i = 3; i <= n; i++)
      e[i] = (i <= 14) ? d[14-i] : (i <= 25) ? d[i-14] : 1'b0;
    return e;
  endfunction : expect_bits
  task automatic push(input logic [11:0] d);
    @(posedge mclk);
    sample_data <= d;
    sample_valid <= 1'b1;
    do @(posedge mclk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
  endtask : push
  task automatic t_exchange(input logic [11:0] d);
    logic [31:0] bits, oe;
    push(d);
    host.exchange(27, bits, oe);
    check("serial bits", bits, expect_bits(d, 27));
    check("output enable", oe, 32'hffff_fffc & 32'h0fff_ffff);
    check("hi-z after select", {31'h0, dout_oe}, 32'h0);
    check("result valid", {31'h0, result_valid}, 32'h1);
    check("result data", {20'h0, result_data}, {20'h0, d});
    result_ready <= 1'b1;
    @(posedge mclk);
    result_ready <= 1'b0;
    repeat (3) @(posedge mclk);
    check("result cleared", {31'h0, result_valid}, 32'h0);
    $display("test exchange done");
  endtask : t_exchange
  // Fill the FIFO with eight words and check it refuses, then drain it with aborted exchanges, one extra on empty
  task automatic t_fill_drain();
    logic [31:0] bits, oe;
    for (int k = 0; k < 8; k++) push(12'h801 + 12'(k) * 12'h111);
    @(posedge mclk);
    check("fifo full", {31'h0, sample_ready}, 32'h0);
    for (int k = 0; k < 9; k++) begin
      host.exchange(14, bits, oe);
      check("drained word", bits, expect_bits(k < 8 ? 12'h801 + 12'(k) * 12'h111 : 12'h000, 14));
    end
    check("fifo empty", {31'h0, sample_ready}, 32'h1);
    $display("test fill and drain done");
  endtask : t_fill_drain
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    t_exchange(12'ha5c);
    t_fill_drain();
    print_verdict();
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule : tb_top
bind adc_serial_readout adc_readout_monitor #(.WIDTH(WIDTH)) mon (.mclk(mclk), .nrst(nrst),
  .select_shutdown_n(select_shutdown_n), .transfer_conversion_clock(transfer_conversion_clock),
  .dout_o(dout_o), .dout_oe(dout_oe), .sampling(sampling), .converting(converting),
  .powered(powered), .result_data(result_data), .result_valid(result_valid),
  .result_ready(result_ready));
